// >>> bench/sqs_motor_model.sv
`timescale 1ns/1ps
module sqs_motor_model #(
  parameter int BRAKE_CYC = 12
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        quick_stop_active,
  input  wire logic        amp_enable,
  input  wire logic        ov_cmd,
  output logic             standstill,
  output logic             overvoltage,
  output logic [31:0]      position
);
  int          brake_cnt_ff;
  logic [31:0] pos_ff;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      brake_cnt_ff <= 0;
    else if (!quick_stop_active)
      brake_cnt_ff <= 0;
    else if (brake_cnt_ff < BRAKE_CYC)
      brake_cnt_ff <= brake_cnt_ff + 1;
  end

  // Shaft turns while powered and not yet stopped
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      pos_ff <= 32'h0000_0000;
    else if (amp_enable && !standstill)
      pos_ff <= pos_ff + 32'h0000_0003;
  end

  assign standstill  = quick_stop_active && (brake_cnt_ff == BRAKE_CYC);
  assign overvoltage = ov_cmd && quick_stop_active && amp_enable;
  assign position    = pos_ff;
endmodule : sqs_motor_model

// >>> bench/tb.sv
`timescale 1ns/1ps
`include "sqs_cfg.svh"
module tb;
  localparam logic [15:0] CFG_LIM = 16'h0400;
  localparam logic [15:0] MOT_PK  = 16'h0600;
  localparam logic [15:0] AMP_PK  = 16'h0700;
  logic        mclk, rst, avs_read, avs_write, stop_in_n, lim_p_n, lim_n_n, fault_reset;
  logic        manual_sel, dev_stop, dev_conf, int_fault, ov_cmd, gear_in;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd, act_pos, setp;
  logic        avs_waitrequest, standstill, overvoltage;
  logic        amp_en, pos_loop, gear_out, func_en, qs_act;
  logic [15:0] cur_lim;
  logic [7:0]  err_code;
  logic [1:0]  err_cls;
  int          error_cnt, samples_checked, cyc;

  sqs_quick_stop sqs_quick_stop_inst (
    .mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .stop_in_n(stop_in_n),
    .positive_travel_limit_in_n(lim_p_n), .negative_travel_limit_in_n(lim_n_n),
    .fault_reset_in(fault_reset), .manual_auto_select_in(manual_sel),
    .dev_stop_cmd(dev_stop), .dev_err_confirm(dev_conf), .internal_estop_fault(int_fault),
    .overvoltage_in(overvoltage), .standstill_in(standstill), .actual_position_in(act_pos),
    .configured_motor_current_limit(CFG_LIM), .motor_peak_current(MOT_PK),
    .amplifier_peak_current(AMP_PK), .gear_pulse_in(gear_in), .amp_enable_ff(amp_en),
    .current_limit_ff(cur_lim), .pos_loop_enable_ff(pos_loop), .setpoint_position_ff(setp),
    .gear_pulse_out_ff(gear_out), .func_enable_ff(func_en), .quick_stop_active_ff(qs_act),
    .error_code_ff(err_code), .error_class_ff(err_cls));

  sqs_motor_model #(.BRAKE_CYC(12)) sqs_motor_model_inst (
    .mclk(mclk), .rst(rst), .quick_stop_active(qs_act), .amp_enable(amp_en),
    .ov_cmd(ov_cmd), .standstill(standstill), .overvoltage(overvoltage), .position(act_pos));

  always #2 mclk = ~mclk;

  // Hang guard, well above the longest expected run
  always @(posedge mclk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      end_sim();
    end
  end

  task end_sim();
    $display("Checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  // Request held until waitrequest is sampled low at a rising edge; data taken there
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 50)
      error_cnt++;
  endtask : bus

  task wait_qs(input logic v);
    int n;
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (qs_act !== v && n < 60);
    chk("quick_stop_active", {31'h0, qs_act}, {31'h0, v});
  endtask : wait_qs

  task wait_still();
    int n;
    n = 0;
    while (standstill !== 1'b1 && n < 60)
    begin
      @(negedge mclk);
      n++;
    end
    repeat (2) @(negedge mclk);
  endtask : wait_still

  task trig(input int k);
    @(posedge mclk);
    case (k)
      0: dev_stop <= 1'b1;
      1: avs_read <= 1'b0;
      2: lim_p_n <= 1'b0;
      3: lim_n_n <= 1'b0;
      default: int_fault <= 1'b1;
    endcase
    if (k == 1)
      bus(1'b1, `SQS_CTRL_OFS, 32'h0000_0001);
    @(posedge mclk);
    dev_stop  <= 1'b0;
    int_fault <= 1'b0;
  endtask : trig

  task ack(input int k);
    if (k == 2)
      bus(1'b1, `SQS_CTRL_OFS, 32'h0000_0002);
    else
    begin
      @(posedge mclk);
      fault_reset <= (k == 0);
      dev_conf    <= (k == 1);
      tick(2);
      fault_reset <= 1'b0;
      dev_conf    <= 1'b0;
    end
  endtask : ack

  task gear_pulse(input logic exp);
    @(posedge mclk);
    gear_in <= 1'b1;
    @(posedge mclk);
    gear_in <= 1'b0;
    @(negedge mclk);
    chk("gear_pulse_out", {31'h0, gear_out}, {31'h0, exp});
  endtask : gear_pulse

  initial
  begin
    {mclk, avs_read, avs_write, fault_reset, manual_sel, dev_stop, dev_conf} = 7'h00;
    {int_fault, ov_cmd, gear_in, cyc, error_cnt, samples_checked} = 0;
    {stop_in_n, lim_p_n, lim_n_n, rst} = 4'hF;
    avs_address    = 4'h0;
    avs_byteenable = 4'hF;
    avs_writedata  = 32'h0;
    tick(10);
    rst <= 1'b0;
    tick(1);
    bus(1'b0, `SQS_QSL_OFS, 32'h0);
    chk("qsl_reset", rd, 32'h0000_03E8);
    bus(1'b1, `SQS_QSL_OFS, 32'h0000_FFFF);
    bus(1'b0, `SQS_QSL_OFS, 32'h0);
    chk("qsl_saturate", rd, {16'h0, `SQS_QSL_MAX});
    bus(1'b1, `SQS_QSL_OFS, 32'h0000_0800);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped_read", rd, 32'h0);
    bus(1'b0, `SQS_CTRL_OFS, 32'h0);
    chk("ctrl_reset", rd, 32'h0);
    chk("run_current", {16'h0, cur_lim}, {16'h0, CFG_LIM});
    gear_pulse(1'b1);
    // Stop input, acknowledge refused while it is still low
    @(posedge mclk);
    stop_in_n <= 1'b0;
    wait_qs(1'b1);
    chk("func_off", {31'h0, func_en}, 32'h0);
    chk("brake_current", {16'h0, cur_lim}, {16'h0, MOT_PK});
    bus(1'b0, `SQS_STAT_OFS, 32'h0);
    chk("stat_brake", {24'h0, rd[7:0]}, 32'h0000_0011);
    gear_pulse(1'b0);
    wait_still();
    chk("pos_loop", {31'h0, pos_loop}, 32'h1);
    chk("setpoint", setp, act_pos);
    chk("clamp_current", {16'h0, cur_lim}, {16'h0, CFG_LIM});
    chk("clamp_amp", {31'h0, amp_en}, 32'h1);
    ack(0);
    wait_qs(1'b1);
    @(posedge mclk);
    stop_in_n <= 1'b1;
    tick(3);
    wait_qs(1'b1);
    ack(0);
    wait_qs(1'b0);
    chk("func_back", {31'h0, func_en}, 32'h1);
    for (int k = 0; k < 5; k++)
    begin
      trig(k);
      wait_qs(1'b1);
      wait_still();
      chk("clamp_loop", {31'h0, pos_loop}, 32'h1);
      @(posedge mclk);
      manual_sel <= 1'b1;
      lim_p_n    <= 1'b1;
      lim_n_n    <= 1'b1;
      ack(k % 3);
      wait_qs(1'b0);
    end
    bus(1'b1, `SQS_CTRL_OFS, 32'h0000_0004);
    trig(0);
    wait_qs(1'b1);
    wait_still();
    chk("amp_off", {31'h0, amp_en}, 32'h0);
    chk("class_2", {30'h0, err_cls}, {30'h0, `SQS_CLS_AMP_OFF});
    ack(1);
    wait_qs(1'b0);
    bus(1'b1, `SQS_CTRL_OFS, 32'h0);
    @(posedge mclk);
    ov_cmd <= 1'b1;
    trig(0);
    wait_qs(1'b1);
    repeat (3) @(negedge mclk);
    chk("ov_amp_off", {31'h0, amp_en}, 32'h0);
    chk("ov_code", {24'h0, err_code}, {24'h0, `SQS_ERR_OVERVOLT});
    @(posedge mclk);
    ov_cmd <= 1'b0;
    ack(0);
    wait_qs(1'b0);
    @(negedge mclk);
    chk("ov_amp_back", {31'h0, amp_en}, 32'h1);
    end_sim();
  end
endmodule : tb

// >>> rtl/sqs_avmm_slave.sv
`timescale 1ns/1ps
module sqs_avmm_slave (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic [3:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic [31:0]           rdata_in,
  output sqs_pkg::sqs_bus_req_s      req
);

  logic        wait_ff;
  logic [31:0] rdata_ff;

  // Every access waits exactly one cycle; data is latched with the release
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      wait_ff <= 1'b1;
    else
      wait_ff <= !(wait_ff && (avs_read || avs_write));
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      rdata_ff <= 32'h0000_0000;
    else if (wait_ff && avs_read)
      rdata_ff <= rdata_in;
  end

  assign avs_waitrequest = wait_ff;
  assign avs_readdata    = rdata_ff;
  assign req.addr   = avs_address;
  assign req.wdata  = avs_writedata;
  assign req.be     = avs_byteenable;
  assign req.wr_stb = avs_write && !wait_ff;
  assign req.rd_stb = avs_read && !wait_ff;

endmodule : sqs_avmm_slave

// >>> rtl/sqs_cfg.svh
`ifndef SQS_CFG_SVH
`define SQS_CFG_SVH

// Register byte offsets
`define SQS_QSL_OFS        4'h0
`define SQS_CTRL_OFS       4'h4
`define SQS_STAT_OFS       4'h8
`define SQS_SETP_OFS       4'hC

// Braking current limit: reset value and upper bound of the setting
`define SQS_QSL_RST        16'h03E8
`define SQS_QSL_MAX        16'h752F

// Control register fields
`define SQS_CTRL_STOP_BIT  0
`define SQS_CTRL_CONF_BIT  1
`define SQS_CTRL_OFF_BIT   2
`define SQS_CTRL_RST       3'h0

// Status register fields
`define SQS_STAT_ST_LSB    0
`define SQS_STAT_CAUSE_LSB 4
`define SQS_STAT_ERR_LSB   8
`define SQS_STAT_CLS_LSB   16

// Error reporting
`define SQS_ERR_NONE       8'h00
`define SQS_ERR_OVERVOLT   8'h05
`define SQS_CLS_NONE       2'h0
`define SQS_CLS_AMP_OFF    2'h2

`endif

// >>> rtl/sqs_in_edge.sv
`timescale 1ns/1ps
module sqs_in_edge #(
  parameter int W = 3
) (
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire logic [W-1:0]  sig_in,
  output logic      [W-1:0]  rise,
  output logic      [W-1:0]  fall
);

  logic [W-1:0] prev_ff;

  // Reset to all-ones so an input held low at release counts as a fall
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      prev_ff <= {W{1'b1}};
    else
      prev_ff <= sig_in;
  end

  assign rise = sig_in & ~prev_ff;
  assign fall = ~sig_in & prev_ff;

endmodule : sqs_in_edge

// >>> rtl/sqs_pkg.sv
package sqs_pkg;

  typedef enum logic [2:0] {
    SQS_RUN,
    SQS_BRAKE,
    SQS_CLAMP,
    SQS_AMP_OFF,
    SQS_OV_TRIP
  } sqs_state_e;

  typedef struct packed {
    logic internal;
    logic limit;
    logic device;
    logic stop_in;
  } sqs_cause_s;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic        wr_stb;
    logic        rd_stb;
  } sqs_bus_req_s;

endpackage : sqs_pkg

// >>> rtl/sqs_quick_stop.sv
// Functional notes
// - Stop input asserted starts a quick stop.
// - Stop command from an input device starts a quick stop.
// - Either travel limit switch reaching its limit starts a quick stop.
// - Internal malfunction needing emergency stop starts a quick stop.
// - Overvoltage while braking: amplifier off, error 5, motor coasts.
// - Braking current limited to setting, default 1000, max 29999, peak-capped.
// - Braking continues until the motor reaches standstill.
// - At standstill enter zero-clamp, or amplifier off as class 2 fault.
// - Zero-clamp: position loop on, setpoint from actual, configured current limit.
// - Cleared only by acknowledge rising edge, device error confirmation or the control register confirm bit.
// - Acknowledge refused while the stop input is still asserted.
// - Gear reference pulses are ignored during quick stop.
// - After acknowledge the previously active function resumes.
`timescale 1ns/1ps
`include "sqs_cfg.svh"
module sqs_quick_stop (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        stop_in_n,
  input  wire logic        positive_travel_limit_in_n,
  input  wire logic        negative_travel_limit_in_n,
  input  wire logic        fault_reset_in,
  input  wire logic        manual_auto_select_in,
  input  wire logic        dev_stop_cmd,
  input  wire logic        dev_err_confirm,
  input  wire logic        internal_estop_fault,
  input  wire logic        overvoltage_in,
  input  wire logic        standstill_in,
  input  wire logic [31:0] actual_position_in,
  input  wire logic [15:0] configured_motor_current_limit,
  input  wire logic [15:0] motor_peak_current,
  input  wire logic [15:0] amplifier_peak_current,
  input  wire logic        gear_pulse_in,
  output logic             amp_enable_ff,
  output logic [15:0]      current_limit_ff,
  output logic             pos_loop_enable_ff,
  output logic [31:0]      setpoint_position_ff,
  output logic             gear_pulse_out_ff,
  output logic             func_enable_ff,
  output logic             quick_stop_active_ff,
  output logic [7:0]       error_code_ff,
  output logic [1:0]       error_class_ff
);

  function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
    min16 = (a < b) ? a : b;
  endfunction : min16

  sqs_pkg::sqs_state_e   state_ff;
  sqs_pkg::sqs_state_e   nxt_state;
  sqs_pkg::sqs_cause_s   cause_ff;
  sqs_pkg::sqs_bus_req_s req;
  logic [15:0]           quick_stop_current_limit_ff;
  logic [2:0]            ctrl_ff;
  logic [31:0]           rdata;
  logic [2:0]            rise;
  logic [2:0]            fall;
  logic                  sw_stop;
  logic                  sw_conf;
  logic                  trig_stop;
  logic                  trig_dev;
  logic                  trig_lim;
  logic                  trig_any;
  logic                  ack_event;
  logic                  ack_ok;
  logic                  stopped;
  logic [15:0]           peak_cap;
  logic [15:0]           qsl_wr;

  sqs_avmm_slave u_bus (
    .mclk            (mclk),
    .rst             (rst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .rdata_in        (rdata),
    .req             (req)
  );

  // Limits trigger on assertion only, so retraction with the switch still active works
  sqs_in_edge #(.W(3)) u_edge (
    .mclk   (mclk),
    .rst    (rst),
    .sig_in ({fault_reset_in, positive_travel_limit_in_n, negative_travel_limit_in_n}),
    .rise   (rise),
    .fall   (fall)
  );

  // Register file
  assign qsl_wr = {req.be[1] ? req.wdata[15:8] : quick_stop_current_limit_ff[15:8],
                   req.be[0] ? req.wdata[7:0]  : quick_stop_current_limit_ff[7:0]};

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      quick_stop_current_limit_ff <= `SQS_QSL_RST;
    else if (req.wr_stb && req.addr == `SQS_QSL_OFS)
      quick_stop_current_limit_ff <= min16(qsl_wr, `SQS_QSL_MAX);
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      ctrl_ff <= `SQS_CTRL_RST;
    else if (req.wr_stb && req.addr == `SQS_CTRL_OFS && req.be[0])
      ctrl_ff <= {req.wdata[`SQS_CTRL_OFF_BIT], 2'b00};
  end

  // Command bits are self-clearing pulses; they never store
  assign sw_stop = req.wr_stb && req.addr == `SQS_CTRL_OFS && req.be[0]
                   && req.wdata[`SQS_CTRL_STOP_BIT];
  assign sw_conf = req.wr_stb && req.addr == `SQS_CTRL_OFS && req.be[0]
                   && req.wdata[`SQS_CTRL_CONF_BIT];

  always_comb
  begin
    rdata = 32'h0000_0000;
    case (req.addr)
      `SQS_QSL_OFS:  rdata[15:0] = quick_stop_current_limit_ff;
      `SQS_CTRL_OFS: rdata[2:0] = ctrl_ff;
      `SQS_STAT_OFS:
      begin
        rdata[`SQS_STAT_ST_LSB +: 3]    = state_ff;
        rdata[`SQS_STAT_CAUSE_LSB +: 4] = cause_ff;
        rdata[`SQS_STAT_ERR_LSB +: 8]   = error_code_ff;
        rdata[`SQS_STAT_CLS_LSB +: 2]   = error_class_ff;
      end
      `SQS_SETP_OFS: rdata = setpoint_position_ff;
      default:       rdata = 32'h0000_0000;
    endcase
  end

  assign trig_stop = !stop_in_n;
  assign trig_dev  = dev_stop_cmd || sw_stop;
  assign trig_lim  = fall[0] || fall[1];
  assign trig_any  = trig_stop || trig_dev || trig_lim || internal_estop_fault;

  assign ack_event = rise[2] || dev_err_confirm || sw_conf;
  assign ack_ok    = ack_event && stop_in_n;
  assign stopped   = state_ff == sqs_pkg::SQS_CLAMP || state_ff == sqs_pkg::SQS_AMP_OFF
                     || state_ff == sqs_pkg::SQS_OV_TRIP;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      sqs_pkg::SQS_RUN:
        if (trig_any)
          nxt_state = sqs_pkg::SQS_BRAKE;
      sqs_pkg::SQS_BRAKE:
        if (overvoltage_in)
          nxt_state = sqs_pkg::SQS_OV_TRIP;
        else if (standstill_in)
          nxt_state = ctrl_ff[`SQS_CTRL_OFF_BIT] ? sqs_pkg::SQS_AMP_OFF : sqs_pkg::SQS_CLAMP;
      sqs_pkg::SQS_CLAMP, sqs_pkg::SQS_AMP_OFF, sqs_pkg::SQS_OV_TRIP:
        if (ack_ok)
          nxt_state = sqs_pkg::SQS_RUN;
      default:
        nxt_state = sqs_pkg::SQS_BRAKE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      state_ff <= sqs_pkg::SQS_RUN;
    else
      state_ff <= nxt_state;
  end

  // Causes accumulate during the stop and clear with the acknowledge
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      cause_ff <= 4'h0;
    else if (stopped && ack_ok)
      cause_ff <= 4'h0;
    else if (state_ff != sqs_pkg::SQS_RUN || trig_any)
      cause_ff <= cause_ff | {internal_estop_fault, trig_lim, trig_dev, trig_stop};
  end

  assign peak_cap = min16(motor_peak_current, amplifier_peak_current);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      current_limit_ff <= 16'h0000;
    else if (nxt_state == sqs_pkg::SQS_BRAKE)
      current_limit_ff <= min16(quick_stop_current_limit_ff, peak_cap);
    else if (nxt_state == sqs_pkg::SQS_CLAMP || nxt_state == sqs_pkg::SQS_RUN)
      current_limit_ff <= configured_motor_current_limit;
    else
      current_limit_ff <= 16'h0000;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      amp_enable_ff <= 1'b0;
    else
      amp_enable_ff <= nxt_state != sqs_pkg::SQS_OV_TRIP && nxt_state != sqs_pkg::SQS_AMP_OFF;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      pos_loop_enable_ff <= 1'b0;
    else
      pos_loop_enable_ff <= nxt_state == sqs_pkg::SQS_CLAMP;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      setpoint_position_ff <= 32'h0000_0000;
    else if (state_ff == sqs_pkg::SQS_BRAKE && nxt_state == sqs_pkg::SQS_CLAMP)
      setpoint_position_ff <= actual_position_in;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      gear_pulse_out_ff <= 1'b0;
    else
      gear_pulse_out_ff <= gear_pulse_in && state_ff == sqs_pkg::SQS_RUN && !trig_any;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      func_enable_ff       <= 1'b0;
      quick_stop_active_ff <= 1'b0;
    end
    else
    begin
      func_enable_ff       <= nxt_state == sqs_pkg::SQS_RUN;
      quick_stop_active_ff <= nxt_state != sqs_pkg::SQS_RUN;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      error_code_ff  <= `SQS_ERR_NONE;
      error_class_ff <= `SQS_CLS_NONE;
    end
    else
    begin
      error_code_ff  <= (nxt_state == sqs_pkg::SQS_OV_TRIP) ? `SQS_ERR_OVERVOLT : `SQS_ERR_NONE;
      error_class_ff <= (nxt_state == sqs_pkg::SQS_AMP_OFF) ? `SQS_CLS_AMP_OFF : `SQS_CLS_NONE;
    end
  end

  property p_trig_stop;
    @(posedge mclk) disable iff (rst)
    state_ff == sqs_pkg::SQS_RUN && !stop_in_n |=> state_ff == sqs_pkg::SQS_BRAKE
      ##0 quick_stop_active_ff && !func_enable_ff;
  endproperty
  a_trig_stop: assert property (p_trig_stop) else $error("stop input ignored");

  property p_trig_dev;
    @(posedge mclk) disable iff (rst)
    state_ff == sqs_pkg::SQS_RUN && dev_stop_cmd |=> state_ff == sqs_pkg::SQS_BRAKE;
  endproperty
  a_trig_dev: assert property (p_trig_dev) else $error("device stop ignored");

  property p_trig_lim;
    @(posedge mclk) disable iff (rst)
    state_ff == sqs_pkg::SQS_RUN && $fell(positive_travel_limit_in_n) |=>
      state_ff == sqs_pkg::SQS_BRAKE && cause_ff.limit;
  endproperty
  a_trig_lim: assert property (p_trig_lim) else $error("limit switch ignored");

  property p_trig_int;
    @(posedge mclk) disable iff (rst)
    state_ff == sqs_pkg::SQS_RUN && internal_estop_fault |=> state_ff == sqs_pkg::SQS_BRAKE;
  endproperty
  a_trig_int: assert property (p_trig_int) else $error("internal fault ignored");

  property p_overvolt;
    @(posedge mclk) disable iff (rst)
    state_ff == sqs_pkg::SQS_BRAKE && overvoltage_in |=>
      !amp_enable_ff && error_code_ff == 8'h05 && !pos_loop_enable_ff;
  endproperty
  a_overvolt: assert property (p_overvolt) else $error("overvoltage not tripped");

  property p_brake_cur;
    @(posedge mclk) disable iff (rst)
    state_ff == sqs_pkg::SQS_BRAKE |-> current_limit_ff <= quick_stop_current_limit_ff
      && current_limit_ff <= motor_peak_current && current_limit_ff <= 16'h752F;
  endproperty
  a_brake_cur: assert property (p_brake_cur) else $error("braking current too high");

  property p_brake_hold;
    @(posedge mclk) disable iff (rst)
    state_ff == sqs_pkg::SQS_BRAKE && !standstill_in && !overvoltage_in |=>
      state_ff == sqs_pkg::SQS_BRAKE && amp_enable_ff;
  endproperty
  a_brake_hold: assert property (p_brake_hold) else $error("braking ended early");

  property p_amp_off;
    @(posedge mclk) disable iff (rst)
    state_ff == sqs_pkg::SQS_BRAKE && standstill_in && !overvoltage_in
      && ctrl_ff[`SQS_CTRL_OFF_BIT] |=> !amp_enable_ff && error_class_ff == 2'h2;
  endproperty
  a_amp_off: assert property (p_amp_off) else $error("amplifier-off reaction wrong");

  property p_clamp;
    @(posedge mclk) disable iff (rst)
    state_ff == sqs_pkg::SQS_BRAKE && standstill_in && !overvoltage_in
      && !ctrl_ff[`SQS_CTRL_OFF_BIT] |=> pos_loop_enable_ff
      && setpoint_position_ff == $past(actual_position_in)
      && current_limit_ff == $past(configured_motor_current_limit);
  endproperty
  a_clamp: assert property (p_clamp) else $error("zero-clamp not set up");

  property p_ack_block;
    @(posedge mclk) disable iff (rst)
    stopped && !stop_in_n |=> state_ff != sqs_pkg::SQS_RUN;
  endproperty
  a_ack_block: assert property (p_ack_block) else $error("ack taken with stop held");

  property p_latched;
    @(posedge mclk) disable iff (rst)
    stopped && !ack_event |=> $stable(state_ff);
  endproperty
  a_latched: assert property (p_latched) else $error("stop cleared without ack");

  property p_resume;
    @(posedge mclk) disable iff (rst)
    stopped && ack_ok |=> func_enable_ff && amp_enable_ff ##1 !quick_stop_active_ff
      || state_ff == sqs_pkg::SQS_BRAKE;
  endproperty
  a_resume: assert property (p_resume) else $error("function not resumed");

  property p_no_pulse;
    @(posedge mclk) disable iff (rst)
    state_ff != sqs_pkg::SQS_RUN |=> !gear_pulse_out_ff;
  endproperty
  a_no_pulse: assert property (p_no_pulse) else $error("gear pulse passed in stop");

  property p_cv_clamp;
    @(posedge mclk) disable iff (rst)
    state_ff == sqs_pkg::SQS_BRAKE ##1 state_ff == sqs_pkg::SQS_CLAMP;
  endproperty
  c_cv_clamp: cover property (p_cv_clamp);

  property p_cv_ov;
    @(posedge mclk) disable iff (rst)
    state_ff == sqs_pkg::SQS_BRAKE ##1 state_ff == sqs_pkg::SQS_OV_TRIP;
  endproperty
  c_cv_ov: cover property (p_cv_ov);

  property p_cv_ack;
    @(posedge mclk) disable iff (rst)
    stopped ##1 state_ff == sqs_pkg::SQS_RUN;
  endproperty
  c_cv_ack: cover property (p_cv_ack);

endmodule : sqs_quick_stop
